// >>> include/tmo_pkg.sv
// Constants and register map of the sixteen-bit timer/counter
`default_nettype none
package tmo_pkg;
   // ***************************************************
   // Register byte offsets on the bus
   // ***************************************************
   localparam logic [7:0] TMO_CTRL_OFS = 8'h00;
   localparam logic [7:0] TMO_LOW_OFS = 8'h04;
   localparam logic [7:0] TMO_HIGH_OFS = 8'h08;
   localparam logic [7:0] TMO_FLAGS_OFS = 8'h0c;
   localparam logic [7:0] TMO_ENABLES_OFS = 8'h10;
   localparam logic [7:0] TMO_PINS_OFS = 8'h14;
   // ***************************************************
   // Field positions of timer_one_control and the overflow bit
   // ***************************************************
   localparam int TMO_RUN_BIT = 0;
   localparam int TMO_SRC_BIT = 1;
   localparam int TMO_NOSYNC_BIT = 2;
   localparam int TMO_OSC_BIT = 3;
   localparam int TMO_PS_LSB = 4;
   localparam int TMO_WIDE_BIT = 7;
   localparam int TMO_OVF_BIT = 0;
   // ***************************************************
   // Reset values, masks and codes
   // ***************************************************
   localparam logic [7:0] TMO_CTRL_RST = 8'h00;
   localparam logic [7:0] TMO_CTRL_MASK = 8'hbf;
   localparam logic [7:0] TMO_BYTE_RST = 8'h00;
   localparam logic [15:0] TMO_COUNT_RST = 16'h0000;
   localparam logic [15:0] TMO_COUNT_MAX = 16'hffff;
   localparam logic [3:0] TMO_SPECIAL_EVENT_MODE = 4'hb;
   localparam logic [2:0] TMO_PSC_RST = 3'h0;
   localparam logic [31:0] TMO_RDATA_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> include/tmo_psc_if.sv
// Link between the timer core and its input prescaler
`timescale 1ns/10ps
`default_nettype none
interface tmo_psc_if;
   logic tick_in;
   logic clear;
   logic [1:0] sel;
   logic tick_out;
   // Core side drives the raw ticks and takes the divided ones
   modport core (output tick_in, output clear, output sel, input tick_out);
   // Prescaler side
   modport psc (input tick_in, input clear, input sel, output tick_out);
endinterface
`default_nettype wire

// >>> hdl/tmo_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module tmo_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else if (ce) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/tmo_prescaler.sv
// Input prescaler of the timer, 1:1 to 1:8
`timescale 1ns/10ps
`default_nettype none
module tmo_prescaler
   import tmo_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Core link
   tmo_psc_if.psc link
);
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [2:0] limit;
   logic at_limit;

   // Terminal count is ratio minus one
   assign limit = 3'((4'h1 << link.sel) - 4'h1);
   assign at_limit = (cnt_reg == limit);
   assign link.tick_out = link.tick_in & at_limit;
   assign cnt_next = link.clear ? TMO_PSC_RST :
                     !link.tick_in ? cnt_reg :
                     at_limit ? TMO_PSC_RST : 3'(cnt_reg + 3'h1);

   // Divider state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= TMO_PSC_RST;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/tmo_timer.sv
// Sixteen-bit timer/counter with AHB-Lite register access
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1 - Counter advances only while timer_run is set.
// R2 - wide_access_enable picks one 16-bit access or two 8-bit accesses.
// R3 - Prescale codes 11,10,01,00 divide input by 8,4,2,1.
// R4 - low_power_osc_enable turns the crystal oscillator on or off.
// R5 - External source counts unsynchronised when sync disable is set; the code still counts synchronised edges, but keeps counting in sleep.
// R6 - With internal source the sync disable bit is ignored.
// R7 - Internal source counts once per instruction cycle.
// R8 - External source counts rising edges of pin or oscillator.
// R9 - Enabled oscillator makes both pins inputs, direction bits ignored.
// R10 - Oscillator keeps running in sleep.
// R11 - Software waits for oscillator start-up before relying on it.
// R12 - Counter runs 0000h to FFFFh, then wraps to 0000h.
// R13 - Every overflow sets and holds overflow_flag.
// R14 - Interrupt request only while overflow_irq_enable is set.
// R15 - Special event trigger resets counter and starts conversion if enabled.
// R16 - Trigger reset never sets overflow_flag.
// R17 - Trigger reset needs timer or synchronised counter mode.
// R18 - Counter write beats a coinciding trigger reset.
// R19 - Wide-mode low byte read copies high byte into buffer.
// R20 - Wide-mode low byte write loads high byte from buffer.
// R21 - Only low byte writes clear the prescaler.
// R22 - External edges pass two synchroniser flops before detection.
module tmo_timer
   import tmo_pkg::*;
(
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Oscillator input pin
   input wire logic osc_input_pin_i,
   output logic osc_input_pin_o,
   output logic osc_input_pin_oe_n,
   // Oscillator output and external count clock pin
   input wire logic osc_output_pin_i,
   output logic osc_output_pin_o,
   output logic osc_output_pin_oe_n,
   // Port latch and direction for the two pins
   input wire logic [1:0] port_c_direction,
   input wire logic [1:0] port_c_data,
   // Oscillator amplifier
   output logic osc_amp_enable,
   // System side
   input wire logic sleep_mode,
   input wire logic cmp_trigger,
   input wire logic [3:0] compare_unit_mode,
   input wire logic adc_enable,
   output logic adc_start,
   output logic irq_request
);
   // ***************************************************
   // Declarations
   // ***************************************************
   tmo_psc_if psc_link ();
   // Registers and their next values
   logic [7:0] ctrl_reg;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [7:0] high_buf_reg;
   logic [7:0] high_buf_next;
   logic flag_reg;
   logic flag_next;
   logic irq_en_reg;
   logic irq_reg;
   logic adc_start_reg;
   logic ext_prev_reg;
   logic dp_valid_reg;
   logic dp_write_reg;
   logic [7:0] dp_addr_reg;
   logic rd_done_reg;
   logic [31:0] rdata_reg;
   // Synchronised pins and control decode
   logic [1:0] pin_sync;
   logic run;
   logic src_ext;
   logic no_sync;
   logic osc_en;
   logic wide;
   logic async_mode;
   logic frozen;
   logic ext_edge;
   logic src_tick;
   logic inc;
   logic trig_hit;
   logic ovf;
   // Bus decode
   logic ap_take;
   logic wr_fire;
   logic rd_fire;
   logic sel_ctrl;
   logic sel_low;
   logic sel_high;
   logic sel_flags;
   logic sel_en;
   logic sel_pins;
   logic wr_ctrl;
   logic wr_low;
   logic wr_high;
   logic wr_flags;
   logic wr_en;
   logic rd_low;
   logic any_count_wr;
   logic [7:0] high_view;
   logic [31:0] rd_val;

   // ***************************************************
   // Helpers
   // ***************************************************
   // Word offset match on the latched data-phase address
   function automatic logic ofs_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return (addr == ofs);
   endfunction

   // ***************************************************
   // Control fields
   // ***************************************************
   // Field picks from timer_one_control
   assign run = ctrl_reg[TMO_RUN_BIT];
   assign src_ext = ctrl_reg[TMO_SRC_BIT];
   assign no_sync = ctrl_reg[TMO_NOSYNC_BIT];
   assign osc_en = ctrl_reg[TMO_OSC_BIT];
   assign wide = ctrl_reg[TMO_WIDE_BIT];
   assign async_mode = src_ext & no_sync; // R5 R6

   // ***************************************************
   // Pins and oscillator
   // ***************************************************
   // Pin levels into the clock domain
   tmo_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .async_in({osc_input_pin_i, osc_output_pin_i}),
      .sync_out(pin_sync)
   ); // R22

   // Pins released while the oscillator owns them
   assign osc_output_pin_oe_n = osc_en | port_c_direction[0]; // R9
   assign osc_input_pin_oe_n = osc_en | port_c_direction[1]; // R9
   assign osc_output_pin_o = port_c_data[0];
   assign osc_input_pin_o = port_c_data[1];
   // Amplifier follows the enable bit only, sleep does not stop it
   assign osc_amp_enable = osc_en; // R4 R10

   // ***************************************************
   // Count source selection
   // ***************************************************
   // Rising edge of the synchronised count pin
   // Edge flop resets low like the idle pin: no false count after reset
   assign ext_edge = pin_sync[0] & ~ext_prev_reg; // R8 R22
   // Instruction clock stops in sleep, unsynchronised counting goes on
   assign frozen = sleep_mode & ~async_mode; // R5
   assign src_tick = src_ext ? ext_edge : 1'b1; // R6 R7 R8
   assign psc_link.tick_in = run & ~frozen & src_tick; // R1
   assign psc_link.sel = ctrl_reg[TMO_PS_LSB+1:TMO_PS_LSB]; // R3
   assign psc_link.clear = wr_low; // R21

   // Divide the raw ticks
   tmo_prescaler u_psc (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .link(psc_link)
   ); // R3

   assign inc = psc_link.tick_out;

   // ***************************************************
   // Bus decode
   // ***************************************************
   // Address phase taken while the bus is ready
   assign ap_take = hsel & hready & htrans[1];
   assign wr_fire = ce & dp_valid_reg & dp_write_reg;
   assign rd_fire = ce & dp_valid_reg & ~dp_write_reg & ~rd_done_reg;
   assign sel_ctrl = ofs_hit(dp_addr_reg, TMO_CTRL_OFS);
   assign sel_low = ofs_hit(dp_addr_reg, TMO_LOW_OFS);
   assign sel_high = ofs_hit(dp_addr_reg, TMO_HIGH_OFS);
   assign sel_flags = ofs_hit(dp_addr_reg, TMO_FLAGS_OFS);
   assign sel_en = ofs_hit(dp_addr_reg, TMO_ENABLES_OFS);
   assign sel_pins = ofs_hit(dp_addr_reg, TMO_PINS_OFS);
   assign wr_ctrl = wr_fire & sel_ctrl;
   assign wr_low = wr_fire & sel_low;
   assign wr_high = wr_fire & sel_high;
   assign wr_flags = wr_fire & sel_flags;
   assign wr_en = wr_fire & sel_en;
   assign rd_low = rd_fire & sel_low;
   // Reads stall one cycle so a preceding write is already visible
   assign hreadyout = ce & ~(dp_valid_reg & ~dp_write_reg & ~rd_done_reg);
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // ***************************************************
   // Read data
   // ***************************************************
   // High byte goes through the buffer in wide mode
   assign high_view = wide ? high_buf_reg : count_reg[15:8]; // R2
   assign rd_val = sel_ctrl ? {24'h0, ctrl_reg & TMO_CTRL_MASK} :
                   sel_low ? {24'h0, count_reg[7:0]} :
                   sel_high ? {24'h0, high_view} :
                   sel_flags ? {31'h0, flag_reg} :
                   sel_en ? {31'h0, irq_en_reg} :
                   sel_pins ? {30'h0, pin_sync[1], pin_sync[0]} :
                   TMO_RDATA_RST;

   // ***************************************************
   // Counter and buffer
   // ***************************************************
   // Compare unit reset is refused in unsynchronised mode
   // since unsynchronised edges could race the reset
   assign trig_hit = cmp_trigger & (compare_unit_mode == TMO_SPECIAL_EVENT_MODE)
                     & ~async_mode; // R15 R17
   // Any write that lands in the counting register itself
   assign any_count_wr = wr_low | (wr_high & ~wide);
   // Wrap from the top value; trigger and writes never count as overflow
   assign ovf = inc & (count_reg == TMO_COUNT_MAX) & ~any_count_wr
                & ~trig_hit; // R12 R16

   // Write first, then trigger reset, then increment
   // A counter write also blocks the increment of that cycle
   always_comb begin
      count_next = count_reg;
      if (wr_low) begin
         count_next[7:0] = hwdata[7:0];
         if (wide) begin
            count_next[15:8] = high_buf_reg; // R20
         end
      end else if (wr_high & ~wide) begin
         count_next[15:8] = hwdata[7:0]; // R2
      end else if (trig_hit) begin
         count_next = TMO_COUNT_RST; // R15 R18
      end else if (inc) begin
         count_next = 16'(count_reg + 16'h1); // R12
      end
   end

   // Buffer loads on wide reads of the low byte or wide writes of itself
   assign high_buf_next = (rd_low & wide) ? count_reg[15:8] : // R19
                          (wr_high & wide) ? hwdata[7:0] : high_buf_reg; // R2

   // Overflow flag: software may clear, a new overflow wins
   // so an overflow in the clearing cycle is never lost
   assign flag_next = (wr_flags ? hwdata[TMO_OVF_BIT] : flag_reg) | ovf; // R13

   // ***************************************************
   // Registers
   // ***************************************************
   // Timer state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= TMO_COUNT_RST;
         high_buf_reg <= TMO_BYTE_RST;
         flag_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else if (ce) begin
         count_reg <= count_next;
         high_buf_reg <= high_buf_next;
         flag_reg <= flag_next;
         ext_prev_reg <= pin_sync[0];
      end
   end

   // Software settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= TMO_CTRL_RST;
         irq_en_reg <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl_reg <= hwdata[7:0] & TMO_CTRL_MASK;
         end
         if (wr_en) begin
            irq_en_reg <= hwdata[TMO_OVF_BIT];
         end
      end
   end

   // Interrupt request and conversion start
   // Request follows the flag on the same edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_reg <= 1'b0;
         adc_start_reg <= 1'b0;
      end else if (ce) begin
         irq_reg <= flag_next & irq_en_reg; // R14
         adc_start_reg <= trig_hit & adc_enable; // R15
      end
   end

   assign irq_request = irq_reg;
   assign adc_start = adc_start_reg;

   // Bus phase tracking
   // Address kept as a word offset; upper address bits alias
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg <= TMO_BYTE_RST;
         rd_done_reg <= 1'b0;
      end else if (ce) begin
         if (hready) begin
            dp_valid_reg <= ap_take;
            dp_write_reg <= hwrite;
            dp_addr_reg <= {haddr[7:2], 2'b00};
            rd_done_reg <= 1'b0;
         end else if (rd_fire) begin
            rd_done_reg <= 1'b1;
         end
      end
   end

   // Read data captured in the stall cycle
   // Captured once per read; hrdata then stands until the next read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= TMO_RDATA_RST;
      end else if (rd_fire) begin
         rdata_reg <= rd_val;
      end
   end

   // Bus size is not checked: every access acts on the whole word
   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0]};
endmodule
`default_nettype wire

// >>> dv/tmo_timer_chk.sv
// Port checker of the sixteen-bit timer/counter
`timescale 1ns/10ps
`default_nettype none
module tmo_timer_chk
   import tmo_pkg::*;
(
   // Bus side
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Pins and system side
   input wire logic osc_input_pin_oe_n,
   input wire logic osc_output_pin_oe_n,
   input wire logic osc_amp_enable,
   input wire logic [1:0] port_c_direction,
   input wire logic cmp_trigger,
   input wire logic [3:0] compare_unit_mode,
   input wire logic adc_enable,
   input wire logic adc_start
);
   logic go;
   // Transfer taken on this edge
   assign go = hsel & htrans[1] & hready & ce;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_RD_WAIT: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WR_NOWAIT: assert property (go && hwrite |=> hreadyout)
      else $error("write stalled");
   AST_RESP_OKAY: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   AST_UNMAP: assert property (go && !hwrite && haddr[7:2] > 6'h05 |-> ##2 hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_OE_IN: assert property (osc_input_pin_oe_n == (osc_amp_enable | port_c_direction[1]))
      else $error("input pin enable wrong");
   AST_OE_OUT: assert property (osc_output_pin_oe_n == (osc_amp_enable | port_c_direction[0]))
      else $error("output pin enable wrong");
   AST_ADC_CAUSE: assert property (adc_start |-> $past(cmp_trigger) && $past(adc_enable)
      && $past(compare_unit_mode) == TMO_SPECIAL_EVENT_MODE)
      else $error("conversion start without trigger");
   AST_ADC_ONE: assert property (adc_start |=> !adc_start)
      else $error("conversion start too long");
   AST_NO_EVENT: assert property (cmp_trigger && compare_unit_mode != TMO_SPECIAL_EVENT_MODE
      |=> !adc_start)
      else $error("trigger acted in wrong mode");
   // Main scenarios reached
   cover property (go && !hwrite);
   cover property (adc_start);
   cover property (!osc_input_pin_oe_n);
endmodule
`default_nettype wire

// >>> dv/tmo_ext_clk_model.sv
// External count clock and crystal pin model
`timescale 1ns/10ps
`default_nettype none
module tmo_ext_clk_model (
   // Pin levels toward the timer
   output logic cnt_pin,
   output logic osc_pin
);
   // Pins rest low outside bursts
   initial begin
      cnt_pin = 1'b0;
      osc_pin = 1'b0;
   end
   // Emits n rising edges at a chosen rate
   task automatic burst(input int n, input int half);
      repeat (n) begin
         #(half) cnt_pin = 1'b1;
         #(half) cnt_pin = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// >>> dv/tmo_timer_tb_top.sv
// Testbench of the sixteen-bit timer/counter
`timescale 1ns/10ps
`default_nettype none
module tmo_timer_tb_top
   import tmo_pkg::*;
   ();
   localparam logic [7:0] CT = TMO_CTRL_OFS;
   localparam logic [7:0] LO = TMO_LOW_OFS;
   localparam logic [7:0] HI = TMO_HIGH_OFS;
   localparam logic [7:0] FL = TMO_FLAGS_OFS;
   logic hclk, hresetn, ce, hsel, hwrite, sleep_mode, cmp_trigger, adc_enable;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, pdir, pdat;
   logic [3:0] cmode;
   logic hreadyout, hresp, ai_o, ai_oe, ao_o, ao_oe, amp, adc_start, irq, cnt_pin, osc_pin;
   logic pa, pb;
   int error_cnt, n_checks, adc_n;
   // Pin levels from all drivers
   assign pa = ai_oe ? osc_pin : ai_o;
   assign pb = ao_oe ? cnt_pin : ao_o;
   tmo_ext_clk_model tmo_ext_clk_model_i (.cnt_pin(cnt_pin), .osc_pin(osc_pin));
   tmo_timer tmo_timer_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .osc_input_pin_i(pa), .osc_input_pin_o(ai_o), .osc_input_pin_oe_n(ai_oe),
      .osc_output_pin_i(pb), .osc_output_pin_o(ao_o), .osc_output_pin_oe_n(ao_oe),
      .port_c_direction(pdir), .port_c_data(pdat), .osc_amp_enable(amp), .sleep_mode,
      .cmp_trigger, .compare_unit_mode(cmode), .adc_enable, .adc_start, .irq_request(irq));
   // Clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // Conversion start pulses
   always @(negedge hclk) begin
      if (adc_start === 1'b1) adc_n++;
   end
   // ***************************************************
   // Bus and compare tasks
   // ***************************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      n_checks++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         error_cnt++;
         $display("[ERR] %0t got %h out of range", $time, g);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic t);
      @(posedge hclk);
      cmp_trigger <= 1'b0;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      hsel <= 1'b1;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      cmp_trigger <= t;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0, 1'b0);
      chk(q, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge hclk);
   endtask
   task automatic pulse();
      @(posedge hclk);
      cmp_trigger <= 1'b1;
      @(posedge hclk);
      cmp_trigger <= 1'b0;
   endtask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_regs();
      rd(CT, 32'h0);
      rd(LO, 32'h0);
      rd(HI, 32'h0);
      rd(FL, 32'h0);
      rd(TMO_ENABLES_OFS, 32'h0);
      rd(8'h18, 32'h0);
      wr(CT, 32'hff);
      idle(20);
      rd(CT, {24'h0, TMO_CTRL_MASK});
      @(posedge hclk);
      pdir <= 2'b00;
      sleep_mode <= 1'b1;
      idle(2);
      chk({30'h0, ai_oe, ao_oe}, 32'h3);
      chk({31'h0, amp}, 32'h1);
      wr(CT, 32'h0);
      idle(4);
      chk({31'h0, amp}, 32'h0);
      rd(TMO_PINS_OFS, 32'h2);
      @(posedge hclk);
      pdir <= 2'b11;
      sleep_mode <= 1'b0;
   endtask
   task automatic t_pre();
      for (int c = 0; c < 4; c++) begin
         wr(CT, 32'h0);
         wr(HI, 32'h0);
         wr(LO, 32'h0);
         wr(CT, {26'h0, c[1:0], 4'h5});
         idle(64);
         wr(CT, 32'h0);
         bus(LO, 1'b0, 32'h0, 1'b0);
         chk_rng(q, (65 >> c) - 1, (65 >> c) + 1);
         idle(5);
         rd(LO, q);
      end
   endtask
   task automatic t_ext();
      wr(LO, 32'h0);
      wr(CT, 32'h3);
      tmo_ext_clk_model_i.burst(10, 23);
      idle(8);
      rd(LO, 32'ha);
      @(posedge hclk);
      sleep_mode <= 1'b1;
      wr(CT, 32'h7);
      tmo_ext_clk_model_i.burst(5, 11);
      idle(8);
      rd(LO, 32'hf);
      wr(CT, 32'h3);
      tmo_ext_clk_model_i.burst(2, 23);
      idle(8);
      rd(LO, 32'hf);
      wr(CT, 32'h6);
      tmo_ext_clk_model_i.burst(3, 23);
      idle(8);
      rd(LO, 32'hf);
      @(posedge hclk);
      sleep_mode <= 1'b0;
   endtask
   task automatic t_wrap();
      wr(CT, 32'h0);
      wr(HI, 32'hff);
      wr(LO, 32'hf0);
      wr(CT, 32'h1);
      idle(40);
      wr(CT, 32'h0);
      rd(HI, 32'h0);
      bus(LO, 1'b0, 32'h0, 1'b0);
      chk_rng(q, 32'h10, 32'h40);
      rd(FL, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(TMO_ENABLES_OFS, 32'h1);
      idle(3);
      chk({31'h0, irq}, 32'h1);
      wr(FL, 32'h0);
      idle(3);
      rd(FL, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_trig();
      int a;
      @(posedge hclk);
      cmode <= TMO_SPECIAL_EVENT_MODE;
      adc_enable <= 1'b1;
      bus(LO, 1'b1, 32'h55, 1'b1);
      rd(LO, 32'h55);
      a = adc_n;
      pulse();
      idle(3);
      rd(LO, 32'h0);
      rd(FL, 32'h0);
      chk(adc_n, a + 1);
      @(posedge hclk);
      cmode <= 4'ha;
      wr(LO, 32'h22);
      pulse();
      idle(3);
      rd(LO, 32'h22);
      chk(adc_n, a + 1);
   endtask
   task automatic t_wide();
      wr(CT, 32'h80);
      wr(HI, 32'h12);
      wr(LO, 32'h34);
      wr(CT, 32'h0);
      rd(HI, 32'h12);
      wr(HI, 32'h77);
      wr(CT, 32'h80);
      rd(LO, 32'h34);
      rd(HI, 32'h77);
   endtask
   task automatic t_ce();
      wr(CT, 32'h0);
      wr(HI, 32'h0);
      wr(LO, 32'h0);
      wr(CT, 32'h1);
      @(posedge hclk);
      ce <= 1'b0;
      idle(10);
      chk({31'h0, hreadyout}, 32'h0);
      @(posedge hclk);
      ce <= 1'b1;
      wr(CT, 32'h0);
      rd(LO, 32'h3);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      error_cnt = 0;
      n_checks = 0;
      ce = 1'b1;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      cmp_trigger = 1'b0;
      sleep_mode = 1'b0;
      adc_enable = 1'b0;
      cmode = 4'h0;
      pdir = 2'h3;
      pdat = 2'h2;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_pre();
      t_ext();
      t_wrap();
      t_trig();
      t_wide();
      t_ce();
      final_report();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      final_report();
   end
endmodule
bind tmo_timer tmo_timer_chk tmo_timer_chk_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .osc_input_pin_oe_n, .osc_output_pin_oe_n,
   .osc_amp_enable, .port_c_direction, .cmp_trigger, .compare_unit_mode, .adc_enable,
   .adc_start);
`default_nettype wire
